// >>> sbf_top.sv
// system flag generation and control bit decoding behind an AXI4-Lite slave
`include "sbf_map.svh"
`timescale 1ns/1ps
`default_nettype none

module sbf_top
	import sbf_pkg::*;
#(
	parameter int unsigned HALF_SEC_CYCLES = (`SBF_HALF_SEC_MS * 1000) * `SBF_CLK_MHZ,
	parameter bit SMALL_VARIANT = 1'b0
) (
	input wire logic CLK,
	input wire logic RESETN,
	input wire sbf_status_t STATUS,
	input wire logic SCAN_TICK,
	input wire logic LIGHT_TIME_ON,
	output var sbf_flags_t FLAGS,
	output logic NET_DISCONNECT,
	output logic BACKLIGHT_ON,
	output logic SCREEN_FROM_MANAGER,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);

	// ****************************************************************
	// functions
	// ****************************************************************

	// word decode shared by read and write paths
	function automatic sbf_sel_t reg_sel(input logic [7:0] addr);
		sbf_sel_t s;
		s = SEL_NONE;
		if (addr[7:2] == 6'(`SBF_FLAGS_OFS >> 2)) begin
			s = SEL_FLAGS;
		end else if (addr[7:2] == 6'(`SBF_CTRL_OFS >> 2)) begin
			s = SEL_CTRL;
		end
		return s;
	endfunction

	// one-scan pulse sequencer: arm on event, fire for one scan, retire
	function automatic sbf_pulse_state_t pulse_step(input sbf_pulse_state_t st,
		input logic trig, input logic tick);
		sbf_pulse_state_t n;
		n = st;
		unique case (st)
			PL_IDLE: begin
				if (trig) n = PL_ARMED;
			end
			PL_ARMED: begin
				if (tick) n = PL_ACTIVE;
			end
			PL_ACTIVE: begin
				if (tick) n = trig ? PL_ARMED : PL_IDLE;
			end
			default: n = PL_IDLE; // unused code or unknown falls back to rest
		endcase
		return n;
	endfunction

	// ****************************************************************
	// input synchroniser
	// ****************************************************************

	sbf_status_t status_meta_reg; // first stage, read only by second
	sbf_status_t status_sync_reg; // clean status levels
	sbf_status_t status_prev_reg; // previous clean levels for edges

	// status pins come from other logic; two stages before use
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			status_meta_reg <= '0;
			status_sync_reg <= '0;
			status_prev_reg <= '0;
		end else begin
			status_meta_reg <= STATUS;
			status_sync_reg <= status_meta_reg;
			status_prev_reg <= status_sync_reg;
		end
	end

	// ****************************************************************
	// half-second toggle
	// ****************************************************************

	logic [31:0] half_cnt_reg; // cycles into the current half period
	logic toggle_reg; // square wave level
	wire logic half_end = (half_cnt_reg == 32'(HALF_SEC_CYCLES - 1)); // last cycle of half
	wire logic [31:0] half_cnt_next = half_end ? 32'h0000_0000 : half_cnt_reg + 32'h0000_0001;

	// free running divider for the 1 Hz square wave
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			half_cnt_reg <= 32'h0000_0000;
			toggle_reg <= 1'b0;
		end else begin
			half_cnt_reg <= half_cnt_next;
			if (half_end) toggle_reg <= ~toggle_reg;
		end
	end

	// ****************************************************************
	// scan pulses
	// ****************************************************************

	sbf_pulse_state_t run_pl_reg; // run entry pulse sequencer
	sbf_pulse_state_t done_pl_reg; // decode done pulse sequencer
	wire logic run_rise = status_sync_reg.run_mode & ~status_prev_reg.run_mode; // stop to run
	wire logic done_rise = status_sync_reg.dcf_done & ~status_prev_reg.dcf_done
		& ~status_sync_reg.dcf_error; // clean finish only
	wire sbf_pulse_state_t run_pl_next = pulse_step(run_pl_reg, run_rise, SCAN_TICK);
	wire sbf_pulse_state_t done_pl_next = pulse_step(done_pl_reg, done_rise, SCAN_TICK);

	// pulses align to scan boundaries so the program sees one whole scan
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			run_pl_reg <= PL_IDLE;
			done_pl_reg <= PL_IDLE;
		end else begin
			run_pl_reg <= run_pl_next;
			done_pl_reg <= done_pl_next;
		end
	end

	// ****************************************************************
	// flag assembly
	// ****************************************************************

	wire logic big = ~SMALL_VARIANT; // features absent on the small variant
	wire logic run_active = (run_pl_next == PL_ACTIVE); // pulse level for next scan
	wire logic done_active = (done_pl_next == PL_ACTIVE);
	wire sbf_flags_t flags_next = '{
		input_sensor_defect: status_sync_reg.sensor_defect & {{2{big}}, 6'h3F},
		analog_out_power_flag: status_sync_reg.ao_power & big,
		time_decode_error_flag: status_sync_reg.dcf_error,
		cellular_session_flag: status_sync_reg.gsm_session & big,
		cellular_available_flag: status_sync_reg.gsm_avail & big,
		modem_carrier_flag: status_sync_reg.modem_dcd & big,
		time_decode_done_flag: done_active,
		time_decode_busy_flag: status_sync_reg.dcf_busy,
		run_entry_inverted_flag: ~run_active,
		run_entry_pulse_flag: run_active,
		network_power_fault_flag: status_sync_reg.asi_comm_fail
			& status_sync_reg.asi_power_lost & big,
		network_link_error_flag: status_sync_reg.asi_comm_fail & big,
		daylight_saving_flag: status_sync_reg.dst_active,
		clock_data_error_flag: status_sync_reg.rtc_error,
		half_second_toggle_flag: toggle_reg,
		const_low_flag: 1'b0,
		const_high_flag: 1'b1
	};

	sbf_flags_t flags_reg; // flags as presented

	// flags register
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			flags_reg <= `SBF_FLAGS_RST;
		end else begin
			flags_reg <= flags_next;
		end
	end
	assign FLAGS = flags_reg;

	// ****************************************************************
	// AXI4-Lite write path
	// ****************************************************************

	logic aw_hold_reg; // write address captured
	logic w_hold_reg; // write data captured
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic awready_reg;
	logic wready_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	sbf_ctrl_t ctrl_reg; // control bits

	wire logic aw_take = S_AXI_AWVALID & awready_reg; // address handshake
	wire logic w_take = S_AXI_WVALID & wready_reg; // data handshake
	wire logic do_write = aw_hold_reg & w_hold_reg; // both halves present
	wire logic aw_hold_next = do_write ? 1'b0 : (aw_hold_reg | aw_take);
	wire logic w_hold_next = do_write ? 1'b0 : (w_hold_reg | w_take);
	wire logic bvalid_next = do_write | (bvalid_reg & ~S_AXI_BREADY);
	wire sbf_sel_t wr_sel = reg_sel(awaddr_reg);
	wire logic ctrl_wr = do_write & (wr_sel == SEL_CTRL) & wstrb_reg[0];
	wire sbf_ctrl_t ctrl_wdata = sbf_ctrl_t'(wdata_reg[3:0]);
	wire sbf_ctrl_t ctrl_next = '{
		screen_source_ctrl: ctrl_wdata.screen_source_ctrl,
		backlight_force_on_ctrl: ctrl_wdata.backlight_force_on_ctrl,
		backlight_force_off_ctrl: ctrl_wdata.backlight_force_off_ctrl,
		network_disconnect_ctrl: ctrl_wdata.network_disconnect_ctrl & big
	};
	wire logic [1:0] bresp_next = (wr_sel == SEL_NONE) ? `SBF_RESP_SLVERR : `SBF_RESP_OKAY;

	// capture halves in either order, answer once both are in
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `SBF_RESP_OKAY;
		end else begin
			aw_hold_reg <= aw_hold_next;
			w_hold_reg <= w_hold_next;
			if (aw_take) awaddr_reg <= S_AXI_AWADDR;
			if (w_take) begin
				wdata_reg <= S_AXI_WDATA;
				wstrb_reg <= S_AXI_WSTRB;
			end
			awready_reg <= ~aw_hold_next & ~bvalid_next;
			wready_reg <= ~w_hold_next & ~bvalid_next;
			bvalid_reg <= bvalid_next;
			if (do_write) bresp_reg <= bresp_next;
		end
	end

	// control register, only byte lane 0 holds bits
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			ctrl_reg <= `SBF_CTRL_RST;
		end else if (ctrl_wr) begin
			ctrl_reg <= ctrl_next;
		end
	end

	assign S_AXI_AWREADY = awready_reg;
	assign S_AXI_WREADY = wready_reg;
	assign S_AXI_BVALID = bvalid_reg;
	assign S_AXI_BRESP = bresp_reg;

	// ****************************************************************
	// AXI4-Lite read path
	// ****************************************************************

	logic arready_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	wire logic ar_take = S_AXI_ARVALID & arready_reg; // read handshake
	wire logic rvalid_next = ar_take | (rvalid_reg & ~S_AXI_RREADY);
	wire sbf_sel_t rd_sel = reg_sel(S_AXI_ARADDR);
	wire logic [31:0] rd_word = (rd_sel == SEL_FLAGS) ? {8'h00, flags_reg} :
		(rd_sel == SEL_CTRL) ? {28'h000_0000, ctrl_reg} : 32'h0000_0000;
	wire logic [1:0] rd_resp = (rd_sel == SEL_NONE) ? `SBF_RESP_SLVERR : `SBF_RESP_OKAY;

	// one read at a time, data frozen until taken
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= `SBF_RESP_OKAY;
		end else begin
			arready_reg <= ~rvalid_next;
			rvalid_reg <= rvalid_next;
			if (ar_take) begin
				rdata_reg <= rd_word;
				rresp_reg <= rd_resp;
			end
		end
	end

	assign S_AXI_ARREADY = arready_reg;
	assign S_AXI_RVALID = rvalid_reg;
	assign S_AXI_RDATA = rdata_reg;
	assign S_AXI_RRESP = rresp_reg;

	// ****************************************************************
	// control outputs
	// ****************************************************************

	logic net_disc_reg;
	logic backlight_reg;
	logic screen_reg;
	wire logic backlight_next = ctrl_reg.backlight_force_on_ctrl
		| (~ctrl_reg.backlight_force_off_ctrl & LIGHT_TIME_ON);

	// decoded control levels towards the rest of the controller
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			net_disc_reg <= 1'b0;
			backlight_reg <= 1'b0;
			screen_reg <= 1'b0;
		end else begin
			net_disc_reg <= ctrl_reg.network_disconnect_ctrl;
			backlight_reg <= backlight_next;
			screen_reg <= ctrl_reg.screen_source_ctrl;
		end
	end

	assign NET_DISCONNECT = net_disc_reg;
	assign BACKLIGHT_ON = backlight_reg;
	assign SCREEN_FROM_MANAGER = screen_reg;

	// ****************************************************************
	// assertions
	// ****************************************************************

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	sequence run_fire_s;
		run_pl_reg == PL_ARMED && SCAN_TICK;
	endsequence

	sequence run_hold_s;
		FLAGS.run_entry_pulse_flag && !SCAN_TICK;
	endsequence

	toggle_edge_a: assert property ($changed(FLAGS.half_second_toggle_flag) |->
		$past(half_cnt_reg, 2) == 32'(HALF_SEC_CYCLES - 1))
		else $error("toggle changed off the half period");
	clk_error_a: assert property (##4 FLAGS.clock_data_error_flag == $past(STATUS.rtc_error, 3))
		else $error("clock data error flag wrong");
	dst_flag_a: assert property (##4 FLAGS.daylight_saving_flag == $past(STATUS.dst_active, 3))
		else $error("daylight flag wrong");
	link_error_a: assert property (##4 FLAGS.network_link_error_flag ==
		($past(STATUS.asi_comm_fail, 3) & big))
		else $error("network link error flag wrong");
	power_fault_a: assert property (FLAGS.network_power_fault_flag |->
		FLAGS.network_link_error_flag)
		else $error("power fault without link error");
	run_pulse_a: assert property (run_fire_s |=> FLAGS.run_entry_pulse_flag)
		else $error("run entry pulse missing");
	run_inverse_a: assert property (FLAGS.run_entry_inverted_flag ==
		!FLAGS.run_entry_pulse_flag)
		else $error("inverted run flag not complement");
	pulse_scan_a: assert property (run_hold_s |=> FLAGS.run_entry_pulse_flag)
		else $error("run pulse ended inside a scan");
	pulse_end_a: assert property (FLAGS.run_entry_pulse_flag && SCAN_TICK &&
		run_pl_next == PL_IDLE |=> !FLAGS.run_entry_pulse_flag)
		else $error("run pulse outlived its scan");
	done_pulse_a: assert property ($rose(FLAGS.time_decode_done_flag) |-> $past(SCAN_TICK))
		else $error("done pulse not on scan boundary");
	sensor_flags_a: assert property (##4 FLAGS.input_sensor_defect[0] ==
		$past(STATUS.sensor_defect[0], 3))
		else $error("sensor defect flag wrong");
	backlight_prio_a: assert property (ctrl_reg.backlight_force_on_ctrl |=> BACKLIGHT_ON)
		else $error("force-on did not light backlight");
	backlight_off_a: assert property (ctrl_reg.backlight_force_off_ctrl &&
		!ctrl_reg.backlight_force_on_ctrl |=> !BACKLIGHT_ON)
		else $error("force-off did not darken backlight");
	small_variant_a: assert property (SMALL_VARIANT |-> !NET_DISCONNECT &&
		!FLAGS.modem_carrier_flag && FLAGS.input_sensor_defect[7:6] == 2'h0)
		else $error("small variant shows absent features");

endmodule

`default_nettype wire

// >>> sbf_map.svh
// offsets, field reset values and timing counts of the system flag block
`ifndef SBF_MAP_SVH
`define SBF_MAP_SVH

// ****************************************************************
// register offsets (byte addresses, one aligned word each)
// ****************************************************************
`define SBF_FLAGS_OFS 8'h00
`define SBF_CTRL_OFS 8'h04

// ****************************************************************
// reset values
// ****************************************************************
`define SBF_FLAGS_RST 24'h000101
`define SBF_CTRL_RST 4'h0

// ****************************************************************
// timing
// ****************************************************************
`define SBF_HALF_SEC_MS 500
`define SBF_CLK_MHZ 200

// ****************************************************************
// bus answers
// ****************************************************************
`define SBF_RESP_OKAY 2'h0
`define SBF_RESP_SLVERR 2'h2

`endif

// >>> sbf_pkg.sv
// types shared by the system flag block
package sbf_pkg;

	// status levels arriving from the rest of the controller
	typedef struct packed {
		logic [7:0] sensor_defect; // bit k is input k+1
		logic ao_power;
		logic gsm_session;
		logic gsm_avail;
		logic modem_dcd;
		logic dcf_error;
		logic dcf_done;
		logic dcf_busy;
		logic run_mode;
		logic asi_power_lost;
		logic asi_comm_fail;
		logic dst_active;
		logic rtc_error;
	} sbf_status_t;

	// system flags as the user program sees them, bit 23 first
	typedef struct packed {
		logic [7:0] input_sensor_defect;
		logic analog_out_power_flag;
		logic time_decode_error_flag;
		logic cellular_session_flag;
		logic cellular_available_flag;
		logic modem_carrier_flag;
		logic time_decode_done_flag;
		logic time_decode_busy_flag;
		logic run_entry_inverted_flag;
		logic run_entry_pulse_flag;
		logic network_power_fault_flag;
		logic network_link_error_flag;
		logic daylight_saving_flag;
		logic clock_data_error_flag;
		logic half_second_toggle_flag;
		logic const_low_flag;
		logic const_high_flag;
	} sbf_flags_t;

	// control bits written by the user program
	typedef struct packed {
		logic screen_source_ctrl;
		logic backlight_force_on_ctrl;
		logic backlight_force_off_ctrl;
		logic network_disconnect_ctrl;
	} sbf_ctrl_t;

	// one-scan pulse sequencer
	typedef enum logic [1:0] {PL_IDLE, PL_ARMED, PL_ACTIVE} sbf_pulse_state_t;

	// register select
	typedef enum logic [1:0] {SEL_FLAGS, SEL_CTRL, SEL_NONE} sbf_sel_t;

endpackage

// >>> sbf_prog_model.sv
// scan source model: program scan boundaries and status levels of the controller
`timescale 1ns/1ps
`default_nettype none

module sbf_prog_model
	import sbf_pkg::*;
#(
	parameter int SCAN_CYCLES = 6
) (
	input wire logic clk,
	input wire logic resetn,
	input wire sbf_status_t status_in,
	output var sbf_status_t status,
	output logic scan_tick
);
	// ****************************************************************
	// scan timing
	// ****************************************************************
	int scan_cnt_reg; // cycles since the last scan boundary

	// one-cycle tick every scan, status levels handed on a cycle later
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scan_cnt_reg <= 0;
			scan_tick <= 1'b0;
			status <= '0;
		end else begin
			status <= status_in;
			if (scan_cnt_reg == SCAN_CYCLES - 1) begin
				scan_cnt_reg <= 0;
				scan_tick <= 1'b1;
			end else begin
				scan_cnt_reg <= scan_cnt_reg + 1;
				scan_tick <= 1'b0;
			end
		end
	end
endmodule

`default_nettype wire

// >>> sbf_top_tb.sv
// self-checking testbench of the system flag block, full and small variants
`include "sbf_map.svh"
`timescale 1ns/1ps
`default_nettype none

module sbf_top_tb
	import sbf_pkg::*;
;
	// ****************************************************************
	// settings and signals
	// ****************************************************************
	localparam int HALF = 10; // shortened half-second count
	localparam int SCAN = 6; // scan period of the model
	localparam logic [23:0] PULSE_MASK = 24'h000584; // toggle and pulse bits
	logic clk = 1'b0;
	logic resetn = 1'b0;
	sbf_status_t status_in = '0;
	sbf_status_t status;
	logic scan_tick;
	logic light = 1'b0;
	sbf_flags_t flags, flags_s;
	logic net, bl, scr, net_s;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int err_count = 0;
	int total_checks = 0;
	logic [15:0] seed = 16'h002D;

	always #2.5 clk = ~clk;

	// ****************************************************************
	// design, small variant on the same bus, scan model
	// ****************************************************************
	sbf_top #(.HALF_SEC_CYCLES(HALF), .SMALL_VARIANT(1'b0)) sbf_top_inst (.CLK(clk),
		.RESETN(resetn), .STATUS(status), .SCAN_TICK(scan_tick), .LIGHT_TIME_ON(light),
		.FLAGS(flags), .NET_DISCONNECT(net), .BACKLIGHT_ON(bl), .SCREEN_FROM_MANAGER(scr),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
	sbf_top #(.HALF_SEC_CYCLES(HALF), .SMALL_VARIANT(1'b1)) sbf_top_small_inst (.CLK(clk),
		.RESETN(resetn), .STATUS(status), .SCAN_TICK(scan_tick), .LIGHT_TIME_ON(light),
		.FLAGS(flags_s), .NET_DISCONNECT(net_s), .BACKLIGHT_ON(), .SCREEN_FROM_MANAGER(),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(),
		.S_AXI_BRESP(), .S_AXI_BVALID(), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(),
		.S_AXI_RDATA(), .S_AXI_RRESP(), .S_AXI_RVALID(), .S_AXI_RREADY(rready));
	sbf_prog_model #(.SCAN_CYCLES(SCAN)) sbf_prog_model_inst (.clk(clk), .resetn(resetn),
		.status_in(status_in), .status(status), .scan_tick(scan_tick));

	// ****************************************************************
	// helpers and reference model
	// ****************************************************************
	// pseudo-random step
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	// level flags expected from status, toggle and pulse bits left at zero
	function automatic logic [23:0] exp_flags(input sbf_status_t s, input bit sv);
		sbf_flags_t e;
		e = '0;
		e.const_high_flag = 1'b1;
		e.clock_data_error_flag = s.rtc_error;
		e.daylight_saving_flag = s.dst_active;
		e.network_link_error_flag = s.asi_comm_fail;
		e.network_power_fault_flag = s.asi_comm_fail & s.asi_power_lost;
		e.time_decode_busy_flag = s.dcf_busy;
		e.time_decode_error_flag = s.dcf_error;
		e.modem_carrier_flag = s.modem_dcd;
		e.cellular_available_flag = s.gsm_avail;
		e.cellular_session_flag = s.gsm_session;
		e.analog_out_power_flag = s.ao_power;
		e.input_sensor_defect = s.sensor_defect;
		// small variant drops the missing flags
		if (sv) begin
			e.network_link_error_flag = 1'b0;
			e.network_power_fault_flag = 1'b0;
			e.modem_carrier_flag = 1'b0;
			e.cellular_available_flag = 1'b0;
			e.cellular_session_flag = 1'b0;
			e.analog_out_power_flag = 1'b0;
			e.input_sensor_defect[7:6] = 2'h0;
		end
		return e;
	endfunction

	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// AXI4-Lite write, address and data offered together
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!(bvalid && bready));
		r = bresp;
		bready <= 1'b0;
	endtask

	// AXI4-Lite read
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// cycles a flag stays high, inverted run flag seen at its start
	task automatic pulse_len(input int b, output int len, output logic inv);
		int n;
		n = 0;
		len = 0;
		while (flags[b] !== 1'b1 && n < 60) begin
			@(posedge clk);
			n++;
		end
		inv = flags[8];
		while (flags[b] === 1'b1 && len < 100) begin
			@(posedge clk);
			len++;
		end
	endtask

	// verdict and end of run
	task close_out;
		if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		close_out();
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		sbf_status_t st;
		logic [31:0] d;
		logic [1:0] r;
		logic [3:0] c;
		logic lt, inv;
		int len, i;
		repeat (20) @(posedge clk);
		chk(32'(flags), 32'h000101); // reset levels
		chk(32'({net, bl, scr, bvalid, rvalid}), 32'h0);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		// square wave high and low times
		len = 0;
		while (flags[2] === 1'b1 && len < 100) begin
			@(posedge clk);
			len++;
		end
		pulse_len(2, len, inv);
		chk(32'(len), 32'(HALF));
		len = 0;
		while (flags[2] === 1'b0 && len < 100) begin
			@(posedge clk);
			len++;
		end
		chk(32'(len), 32'(HALF));
		// random status levels, read directly and over the bus
		for (i = 0; i < 8; i++) begin
			seed = lfsr(lfsr(seed));
			st = {seed[11:0], seed[15:8]};
			st.run_mode = 1'b0;
			st.dcf_done = 1'b0;
			status_in <= st;
			repeat (5) @(posedge clk);
			chk(32'(flags & ~PULSE_MASK), 32'(exp_flags(st, 0)));
			chk(32'(flags_s & ~PULSE_MASK), 32'(exp_flags(st, 1)));
			axi_rd(`SBF_FLAGS_OFS, d, r);
			chk(d & ~32'(PULSE_MASK), 32'(exp_flags(st, 0)));
		end
		// two stop to run entries
		st = '0;
		for (i = 0; i < 2; i++) begin
			st.run_mode = 1'b0;
			status_in <= st;
			repeat (5) @(posedge clk);
			st.run_mode = 1'b1;
			status_in <= st;
			pulse_len(7, len, inv);
			chk(32'(len), 32'(SCAN));
			chk(32'({inv, flags[8]}), 32'h1);
		end
		// clean decode finish pulses, failed one does not
		st.dcf_done = 1'b1;
		status_in <= st;
		pulse_len(10, len, inv);
		chk(32'(len), 32'(SCAN));
		st.dcf_done = 1'b0;
		st.dcf_error = 1'b1;
		status_in <= st;
		repeat (5) @(posedge clk);
		st.dcf_done = 1'b1;
		status_in <= st;
		pulse_len(10, len, inv);
		chk(32'(len), 32'h0);
		chk(32'(flags.time_decode_error_flag), 32'h1);
		// every control combination, each with a pseudo-random light-time level
		for (i = 0; i < 16; i++) begin
			c = 4'(i);
			seed = lfsr(seed);
			lt = seed[0];
			light <= lt;
			axi_wr(`SBF_CTRL_OFS, 32'(c), 4'hF, r);
			chk(32'(r), 32'(`SBF_RESP_OKAY));
			repeat (3) @(posedge clk);
			chk(32'({net, bl, scr, net_s}), 32'({c[0], c[2] | (!c[1] & lt), c[3], 1'b0}));
			axi_rd(`SBF_CTRL_OFS, d, r);
			chk(d, 32'(c));
		end
		// refused and ignored accesses
		axi_wr(8'h08, 32'hFFFFFFFF, 4'hF, r);
		chk(32'(r), 32'(`SBF_RESP_SLVERR));
		axi_rd(8'h08, d, r);
		chk({d[29:0], r}, 32'(`SBF_RESP_SLVERR));
		axi_wr(`SBF_FLAGS_OFS, 32'h0, 4'hF, r);
		chk(32'(r), 32'(`SBF_RESP_OKAY));
		axi_wr(`SBF_CTRL_OFS, 32'h5, 4'h0, r);
		axi_rd(`SBF_CTRL_OFS, d, r);
		chk(d, 32'hF);
		axi_rd(`SBF_FLAGS_OFS, d, r);
		chk(d & ~32'(PULSE_MASK), 32'(exp_flags(st, 0)));
		close_out();
	end
endmodule

`default_nettype wire
